// ==== rtl/sirq_map.vh ====
`ifndef SIRQ_MAP_VH
`define SIRQ_MAP_VH
// ****************************************
// register word addresses (byte address = index * 4)
// ****************************************
`define SIRQ_IDX_MASK 8'hA0
`define SIRQ_IDX_FLAGS 8'hA1
`define SIRQ_IDX_SEC 8'h9E
`define SIRQ_IDX_ID0 8'h9F
`define SIRQ_IDX_ID1 8'h9D
`define SIRQ_IDX_PS0 8'hA2
`define SIRQ_ADR_HI 9
`define SIRQ_ADR_LO 2
// ****************************************
// field positions and widths
// ****************************************
`define SIRQ_NSRC 9
`define SIRQ_B_LEARN 8
`define SIRQ_B_SEC_HI 7
`define SIRQ_B_SEC_LO 2
`define SIRQ_B_OVF 1
`define SIRQ_B_STATE 0
`define SIRQ_SEC_W 13
`define SIRQ_ZERO16 16'h0000
`define SIRQ_ZERO32 32'h0000_0000
`define SIRQ_ZERO9 9'h000
`define SIRQ_ZERO13 13'h0000
`define SIRQ_ZERO4 4'h0
`define SIRQ_ZERO12 12'h000
`define SIRQ_ZERO8 8'h00
`define SIRQ_ZERO2 2'h0
`define SIRQ_ONE2 2'h1
`define SIRQ_PAD7 7'h00
`define SIRQ_PAD3 3'h0
`define SIRQ_ONES9 9'h1FF
// byte lanes of a 16-bit register word
`define SIRQ_LANE0_HI 7
`define SIRQ_LANE0_LO 0
`define SIRQ_LANE1_HI 15
`define SIRQ_LANE1_LO 8
`define SIRQ_LANE0 0
`define SIRQ_LANE1 1
// product code split
`define SIRQ_PC_LOW_HI 11
`define SIRQ_PC_LOW_LO 0
`define SIRQ_PC_HIGH_HI 15
`define SIRQ_PC_HIGH_LO 12
// synchronised port state: port 1 above port 0
`define SIRQ_PS_P1_HI 7
`define SIRQ_PS_P1_LO 4
`define SIRQ_PS_P0_HI 3
`define SIRQ_PS_P0_LO 0
// cycles until the third synchroniser stage holds a real pin value
`define SIRQ_FILL_CYC 2'h3
`endif

// ==== rtl/sirq_top.v ====
// Added by the designer: the Wishbone register port.
`include "sirq_map.vh"

// ****************************************
// switch interrupt and port status block
// ****************************************
// one clock domain: the register port is classic wishbone with one ack
// per request; the port state pins are the only asynchronous inputs and
// pass a three stage synchroniser before anything looks at them
module sirq_top #(
  parameter [15:0] PRODUCT_CODE = 16'h1234, // arbitrary value
  parameter [3:0] VERSION_NUMBER = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RST_B,
  // classic wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [9:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // event sources, same clock, one-cycle pulses
  input wire LEARN_DONE,
  input wire [5:0] SEC_VIOLATION,
  input wire CNT_OVERFLOW,
  // port 0 and 1 state from the phys, asynchronous levels
  input wire [3:0] PORT0_STATE,
  input wire [3:0] PORT1_STATE,
  // port 2 to 5 change notice, same clock, one-cycle pulse
  input wire OTHER_PORT_CHANGE,
  // interrupt
  output reg IRQ
);

  // ****************************************
  // helper functions
  // ****************************************

  // true when the word index of a request names the given register
  function sel_word;
    input [7:0] idx;
    input [7:0] want;
    begin
      sel_word = (idx == want);
    end
  endfunction

  // merge a 16-bit register word with the byte lanes that a write enables;
  // lanes left out keep the old bits, so a byte write never disturbs the rest
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input lane0;
    input lane1;
    begin
      lane_merge = old_val;
      if (lane0) begin
        lane_merge[`SIRQ_LANE0_HI:`SIRQ_LANE0_LO] =
          new_val[`SIRQ_LANE0_HI:`SIRQ_LANE0_LO];
      end
      if (lane1) begin
        lane_merge[`SIRQ_LANE1_HI:`SIRQ_LANE1_LO] =
          new_val[`SIRQ_LANE1_HI:`SIRQ_LANE1_LO];
      end
    end
  endfunction

  // ****************************************
  // port state synchronisers
  // ****************************************
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg [7:0] sync3_q;
  reg [7:0] stable_q;
  reg [1:0] fill_q;
  reg state_init_q;
  wire [7:0] raw_state;
  wire fill_done;
  wire state_agree;
  wire state_change;

  // port 1 sits in the upper nibble, port 0 in the lower one
  assign raw_state = {PORT1_STATE, PORT0_STATE};

  // the chain is filled with pin values once three edges have passed
  assign fill_done = (fill_q == `SIRQ_FILL_CYC);

  // only the second and third stage are compared; the first may be metastable
  assign state_agree = (sync2_q == sync3_q);

  // the first settled value after reset is the start point, not a change
  assign state_change = state_init_q & state_agree & (sync3_q != stable_q);

  // three flop chain, fill counter and debounced stable copy
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= `SIRQ_ZERO8;
      sync2_q <= `SIRQ_ZERO8;
      sync3_q <= `SIRQ_ZERO8;
      stable_q <= `SIRQ_ZERO8;
      fill_q <= `SIRQ_ZERO2;
      state_init_q <= 1'b0;
    end else begin
      sync1_q <= raw_state;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // the counter stops once full; it only gates the start point
      if (!fill_done) begin
        fill_q <= fill_q + `SIRQ_ONE2;
      end
      // a value is taken only when two stages agree, so a bouncing pin
      // does not reach software half way
      if (state_agree) begin
        stable_q <= sync3_q;
      end
      // the zeros left in the chain by reset must not count as a change
      if (fill_done & state_agree) begin
        state_init_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // register bus decode
  // ****************************************
  reg [`SIRQ_NSRC-1:0] mask_q;
  reg [`SIRQ_NSRC-1:0] flags_q;
  reg [`SIRQ_SEC_W-1:0] sec_q;
  reg [`SIRQ_NSRC-1:0] mask_d;
  reg [`SIRQ_SEC_W-1:0] sec_d;
  reg [15:0] mask_word_d;
  reg [15:0] sec_word_d;
  reg [15:0] rdata_d;
  wire [7:0] word_idx;
  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  wire wr_lo;
  wire wr_hi;
  wire wr_mask;
  wire wr_sec;
  wire wr_flags;
  wire rd_flags;

  // byte address in, word index used everywhere
  assign word_idx = WB_ADR_I[`SIRQ_ADR_HI:`SIRQ_ADR_LO];

  // a request is answered once; ack drops for a cycle between requests
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr = bus_req & WB_WE_I;
  assign bus_rd = bus_req & ~WB_WE_I;

  // only the two low byte lanes carry register bits
  assign wr_lo = bus_wr & WB_SEL_I[`SIRQ_LANE0];
  assign wr_hi = bus_wr & WB_SEL_I[`SIRQ_LANE1];

  // per register strobes
  assign wr_mask = bus_wr & sel_word(word_idx, `SIRQ_IDX_MASK);
  assign wr_sec = bus_wr & sel_word(word_idx, `SIRQ_IDX_SEC);
  assign wr_flags = bus_wr & sel_word(word_idx, `SIRQ_IDX_FLAGS);
  assign rd_flags = bus_rd & sel_word(word_idx, `SIRQ_IDX_FLAGS);

  // read data mux, unmapped words read zero
  always @* begin
    case (word_idx)
      `SIRQ_IDX_MASK: begin
        rdata_d = {`SIRQ_PAD7, mask_q};
      end
      `SIRQ_IDX_FLAGS: begin
        rdata_d = {`SIRQ_PAD7, flags_q};
      end
      `SIRQ_IDX_SEC: begin
        rdata_d = {`SIRQ_PAD3, sec_q};
      end
      `SIRQ_IDX_ID0: begin
        rdata_d = {PRODUCT_CODE[`SIRQ_PC_LOW_HI:`SIRQ_PC_LOW_LO], VERSION_NUMBER};
      end
      `SIRQ_IDX_ID1: begin
        rdata_d = {`SIRQ_ZERO12, PRODUCT_CODE[`SIRQ_PC_HIGH_HI:`SIRQ_PC_HIGH_LO]};
      end
      `SIRQ_IDX_PS0: begin
        rdata_d = {`SIRQ_ZERO4, stable_q[`SIRQ_PS_P1_HI:`SIRQ_PS_P1_LO],
          `SIRQ_ZERO4, stable_q[`SIRQ_PS_P0_HI:`SIRQ_PS_P0_LO]};
      end
      default: begin
        rdata_d = `SIRQ_ZERO16;
      end
    endcase
  end

  // ****************************************
  // writable registers
  // ****************************************

  // next mask and security words; the padding bits above the register
  // are thrown away, so writes to them are quietly ignored
  always @* begin
    mask_word_d = lane_merge({`SIRQ_PAD7, mask_q},
      WB_DAT_I[`SIRQ_LANE1_HI:`SIRQ_LANE0_LO], wr_lo, wr_hi);
    sec_word_d = lane_merge({`SIRQ_PAD3, sec_q},
      WB_DAT_I[`SIRQ_LANE1_HI:`SIRQ_LANE0_LO], wr_lo, wr_hi);
    mask_d = mask_q;
    sec_d = sec_q;
    if (wr_mask) begin
      mask_d = mask_word_d[`SIRQ_NSRC-1:`SIRQ_LANE0_LO];
    end
    if (wr_sec) begin
      sec_d = sec_word_d[`SIRQ_SEC_W-1:`SIRQ_LANE0_LO];
    end
  end

  // the security word only stores; nothing in this block acts on it
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_q <= `SIRQ_ZERO9;
      sec_q <= `SIRQ_ZERO13;
    end else begin
      mask_q <= mask_d;
      sec_q <= sec_d;
    end
  end

  // ****************************************
  // bus answer
  // ****************************************

  // one ack per request, a cycle after the request is seen, read data registered with it;
  // the data bus reads zero outside the ack cycle so a sloppy master
  // that samples late sees nothing stale
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `SIRQ_ZERO32;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_rd) begin
        WB_DAT_O <= {`SIRQ_ZERO16, rdata_d};
      end else begin
        WB_DAT_O <= `SIRQ_ZERO32;
      end
    end
  end

  // ****************************************
  // interrupt flags
  // ****************************************
  reg [`SIRQ_NSRC-1:0] event_d;
  reg [`SIRQ_NSRC-1:0] clear_d;
  reg [`SIRQ_NSRC-1:0] flags_d;
  reg [15:0] w1c_word_d;

  // gather the event pulses into flag positions
  always @* begin
    event_d = `SIRQ_ZERO9;
    event_d[`SIRQ_B_LEARN] = LEARN_DONE;
    event_d[`SIRQ_B_SEC_HI:`SIRQ_B_SEC_LO] = SEC_VIOLATION;
    event_d[`SIRQ_B_OVF] = CNT_OVERFLOW;
    event_d[`SIRQ_B_STATE] = state_change | OTHER_PORT_CHANGE;
  end

  // a read clears the whole register; a write clears the bits written one,
  // so software that must not lose events can also clear selectively
  always @* begin
    w1c_word_d = lane_merge(`SIRQ_ZERO16,
      WB_DAT_I[`SIRQ_LANE1_HI:`SIRQ_LANE0_LO], wr_lo, wr_hi);
    clear_d = `SIRQ_ZERO9;
    if (rd_flags) begin
      clear_d = `SIRQ_ONES9;
    end else if (wr_flags) begin
      clear_d = w1c_word_d[`SIRQ_NSRC-1:`SIRQ_LANE0_LO];
    end
    // set beats the clear: an event in the clearing cycle stays pending
    flags_d = (flags_q & ~clear_d) | event_d;
  end

  // the interrupt follows the next flags and next mask, so it never lags
  // a mask write or a clear by a cycle
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags_q <= `SIRQ_ZERO9;
      IRQ <= 1'b0;
    end else begin
      flags_q <= flags_d;
      IRQ <= |(flags_d & mask_d);
    end
  end

endmodule // sirq_top

// ==== tb/sirq_checker.sv ====
module sirq_checker #(parameter [15:0] PRODUCT_CODE = 16'h0,
  parameter [3:0] VERSION_NUMBER = 4'h0) (
  // watched ports
  input wire SYS_CLK,
  input wire RST_B,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [9:0] WB_ADR_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  sequence take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  ack_late_a: assert property (take |=> WB_ACK_O) else $error("a");
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("o");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I)) else $error("c");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 0) else $error("d");
  dat_hi_a: assert property (WB_DAT_O[31:16] == 16'h0) else $error("h");
  irq_hold_a: assert property (IRQ && !WB_CYC_I |=> IRQ) else $error("q");
  id_low_a: assert property (take ##0 !WB_WE_I && WB_ADR_I[9:2] == 8'h9F |=>
    WB_DAT_O == {16'h0, PRODUCT_CODE[11:0], VERSION_NUMBER}) else $error("i");
  ps_res_a: assert property (take ##0 !WB_WE_I && WB_ADR_I[9:2] == 8'hA2 |=>
    !(WB_DAT_O & 32'hF0F0)) else $error("p");
endmodule // sirq_checker
bind sirq_top sirq_checker #(.PRODUCT_CODE(PRODUCT_CODE),
  .VERSION_NUMBER(VERSION_NUMBER)) i_c (.*);

// ==== tb/sirq_top_bench.sv ====
module sirq_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 0, rst_b = 0, cyc = 0, we = 0;
  reg [31:0] wd = 0, m, adr = 0, ev = 0, ps = 32'hA05;
  wire [31:0] rd;
  wire ack, irq;
  integer fails = 0, num_checks = 0, seed = 81, i, n, mdl_mask = 0, mdl_flags = 0;
  integer evq[$];
  sirq_top #(.PRODUCT_CODE(16'hBEEF), .VERSION_NUMBER(4'h7)) i_sirq_top (.SYS_CLK(clk),
    .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr[9:0]),
    .WB_SEL_I(4'h3), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .LEARN_DONE(ev[8]),
    .SEC_VIOLATION(ev[7:2]), .CNT_OVERFLOW(ev[1]), .PORT0_STATE(ps[3:0]),
    .PORT1_STATE(ps[11:8]), .OTHER_PORT_CHANGE(ev[0]), .IRQ(irq));
  // clock
  initial forever #50 clk = ~clk;
  task chk(input [31:0] s, input [31:0] e);
    num_checks = num_checks + 1;
    fails = fails + (s !== e);
    if (s !== e) $display("BAD %0t %h %h", $time, s, e);
  endtask
  task bus(input w, input [7:0] x, input [31:0] d);
    @(posedge clk);
    {cyc, we, wd, adr} <= {1'b1, w, d, 22'h0, x, 2'b00};
    for (n = 0; n < 20 && (n == 0 || ack !== 1'b1); n = n + 1) @(posedge clk);
    if (ack !== 1'b1) fails = fails + 1;
    cyc <= 1'b0;
  endtask
  task rdc(input [7:0] x, input [31:0] e);
    bus(1'b0, x, 32'h0);
    chk(rd, e);
  endtask
  task wrap_up;
    $display("%0d checks %0d bad", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, far past the run
  initial begin
    #400000 fails = fails + 1;
    wrap_up;
  end
  // reset, then the tests
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdc(8'h9F, 32'hEEF7);
    rdc(8'h9D, 32'hB);
    rdc(8'h13, 32'h0);
    rdc(8'hA2, ps & 32'hF0F);
    $display("ident done");
    repeat (2) begin
      m = $random(seed);
      bus(1'b1, 8'hA0, m);
      mdl_mask = m & 32'h1FF;
      rdc(8'hA0, mdl_mask);
      for (i = 0; i < 9; i = i + 1) begin
        ev <= 32'h1 << i;
        evq.push_back(i);
        @(posedge clk);
        ev <= 32'h0;
        mdl_flags = 32'h1 << evq.pop_front();
        @(posedge clk);
        chk(irq, |(mdl_flags & mdl_mask));
        rdc(8'hA1, mdl_flags);
        mdl_flags = 0;
        chk(irq, |(mdl_flags & mdl_mask));
      end
    end
    $display("events done");
    bus(1'b1, 8'hA0, 32'h1FF);
    mdl_mask = 32'h1FF;
    m = ($random(seed) & 32'h1FF) | 32'h2;
    ev <= m;
    @(posedge clk);
    ev <= 32'h0;
    @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b1, 8'hA1, m & 32'hFF);
    mdl_flags = m & 32'h100;
    chk(irq, mdl_flags != 0);
    rdc(8'hA1, mdl_flags);
    chk(irq, 1'b0);
    $display("clear done");
    ps <= ps ^ (($random(seed) & 32'hF0F) | 32'h1);
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    rdc(8'hA1, 32'h1);
    rdc(8'hA2, ps & 32'hF0F);
    chk(irq, 1'b0);
    $display("ports done");
    wrap_up;
  end
endmodule // sirq_top_bench
